// [src/cmae_pkg.sv]
// Package of timing forms, operation kinds and constants for the move/arith decoder
// ----------------------------------------------------------------
// ----------------------------------------------------------------
package cmae_pkg;
	typedef struct packed {
		logic [1:0] len;
		logic [2:0] cyc;
	} cmae_timing_s;

	typedef enum logic [3:0] {
		OP_ACC_LOAD, OP_MEM_STORE, OP_POINTER_LOAD, OP_CODE_READ, OP_EXCHANGE, OP_NIBBLE_SWAP,
		OP_ADD, OP_ADD_CARRY, OP_SUB_BORROW, OP_AUX, OP_UNKNOWN
	} cmae_op_e;

	localparam cmae_timing_s T_MOV_A_REG = '{len: 2'h1, cyc: 3'h1};
	localparam cmae_timing_s T_MOV_A_DIR = '{len: 2'h2, cyc: 3'h2};
	localparam cmae_timing_s T_MOV_A_IND = '{len: 2'h1, cyc: 3'h2};
	localparam cmae_timing_s T_MOV_A_IMM = '{len: 2'h2, cyc: 3'h2};
	localparam cmae_timing_s T_MOV_REG_A = '{len: 2'h1, cyc: 3'h2};
	localparam cmae_timing_s T_MOV_REG_DIR = '{len: 2'h2, cyc: 3'h4};
	localparam cmae_timing_s T_MOV_REG_IMM = '{len: 2'h2, cyc: 3'h2};
	localparam cmae_timing_s T_MOV_DIR_SRC = '{len: 2'h2, cyc: 3'h3};
	localparam cmae_timing_s T_MOV_DIR_DIR = '{len: 2'h3, cyc: 3'h4};
	localparam cmae_timing_s T_MOV_DIR_IND = '{len: 2'h2, cyc: 3'h4};
	localparam cmae_timing_s T_MOV_DIR_IMM = '{len: 2'h3, cyc: 3'h3};
	localparam cmae_timing_s T_MOV_IND_A = '{len: 2'h1, cyc: 3'h3};
	localparam cmae_timing_s T_MOV_IND_SRC = '{len: 2'h2, cyc: 3'h3};
	localparam cmae_timing_s T_MOV_POINTER = '{len: 2'h3, cyc: 3'h3};
	localparam cmae_timing_s T_CODE_READ = '{len: 2'h1, cyc: 3'h4};
	localparam cmae_timing_s T_AUX_MOVE = '{len: 2'h1, cyc: 3'h1};
	localparam cmae_timing_s T_PUSH = '{len: 2'h2, cyc: 3'h4};
	localparam cmae_timing_s T_POP = '{len: 2'h2, cyc: 3'h3};
	localparam cmae_timing_s T_EXCH_REG = '{len: 2'h1, cyc: 3'h3};
	localparam cmae_timing_s T_EXCH_DIR = '{len: 2'h2, cyc: 3'h4};
	localparam cmae_timing_s T_EXCH_IND = '{len: 2'h1, cyc: 3'h4};
	localparam cmae_timing_s T_ARITH_REG = '{len: 2'h1, cyc: 3'h2};
	localparam cmae_timing_s T_ARITH_DIR = '{len: 2'h2, cyc: 3'h3};
	localparam cmae_timing_s T_ARITH_IND = '{len: 2'h1, cyc: 3'h3};
	localparam cmae_timing_s T_ARITH_IMM = '{len: 2'h2, cyc: 3'h2};
	localparam cmae_timing_s T_UNKNOWN = '{len: 2'h1, cyc: 3'h1};

	localparam logic [7:0] BYTE_RESET = 8'h00;
	localparam logic [15:0] ADDR_RESET = 16'h0000;
	localparam logic [7:0] OPC_CODE_READ_PC = 8'h83;
endpackage : cmae_pkg

// [src/cmae_decoder.sv]
// Decoder and execution timer for move, exchange, stack and add/subtract forms
`timescale 1ns/10ps
`default_nettype none
module cmae_decoder (
	input wire logic clock, // 40 MHz system clock
	input wire logic reset, // Synchronous, active high
	input wire logic opcode_valid, // Opcode offered this cycle
	input wire logic [7:0] opcode_in, // Opcode byte
	input wire logic [7:0] operand_in, // Source byte for the form
	input wire logic [7:0] acc_in, // Current accumulator
	input wire logic carry_in, // Current carry flag
	input wire logic [15:0] data_pointer_in, // Current data_pointer_16
	input wire logic [15:0] pc_in, // Program counter after the opcode
	output logic busy, // Executing, opcodes refused
	output logic done, // One-cycle end of execution
	output logic [1:0] length, // Encoded length in bytes
	output logic [2:0] cycles, // Execution time in cycles
	output logic unsupported, // Last form was an aux_memory_move
	output logic unknown, // Last opcode is outside this group
	output logic [15:0] code_addr, // code_memory_read address
	output logic acc_write, // Pulse: write acc_result
	output logic [7:0] acc_result, // New accumulator
	output logic mem_write, // Pulse: write mem_result to destination
	output logic [7:0] mem_result, // Byte for register, direct or indirect RAM
	output logic flags_write, // Pulse: update carry, aux carry, overflow
	output logic carry_out, // Carry or borrow
	output logic aux_carry_out, // Nibble carry or borrow
	output logic overflow_out // Signed overflow
);
	import cmae_pkg::*;

	// ----------------------------------------------------------------
	// Decode
	// ----------------------------------------------------------------
	cmae_timing_s dec_timing;
	cmae_op_e dec_op;
	cmae_op_e arith_op;
	logic dec_src_acc;
	logic accept;
	logic busy_reg;

	assign accept = opcode_valid && !busy_reg;
	assign arith_op = opcode_in[7] ? OP_SUB_BORROW : (opcode_in[4] ? OP_ADD_CARRY : OP_ADD);

	always_comb begin
		dec_timing = T_UNKNOWN;
		dec_op = OP_UNKNOWN;
		dec_src_acc = 1'b0;
		unique casez (opcode_in)
			8'b1110_1???: begin dec_timing = T_MOV_A_REG; dec_op = OP_ACC_LOAD; end
			8'hE5: begin dec_timing = T_MOV_A_DIR; dec_op = OP_ACC_LOAD; end
			8'b1110_011?: begin dec_timing = T_MOV_A_IND; dec_op = OP_ACC_LOAD; end
			8'h74: begin dec_timing = T_MOV_A_IMM; dec_op = OP_ACC_LOAD; end
			8'b1111_1???: begin
				dec_timing = T_MOV_REG_A;
				dec_op = OP_MEM_STORE;
				dec_src_acc = 1'b1;
			end
			8'b1010_1???: begin dec_timing = T_MOV_REG_DIR; dec_op = OP_MEM_STORE; end
			8'b0111_1???: begin dec_timing = T_MOV_REG_IMM; dec_op = OP_MEM_STORE; end
			8'hF5: begin
				dec_timing = T_MOV_DIR_SRC;
				dec_op = OP_MEM_STORE;
				dec_src_acc = 1'b1;
			end
			8'b1000_1???: begin dec_timing = T_MOV_DIR_SRC; dec_op = OP_MEM_STORE; end
			8'h85: begin dec_timing = T_MOV_DIR_DIR; dec_op = OP_MEM_STORE; end
			8'h75: begin dec_timing = T_MOV_DIR_IMM; dec_op = OP_MEM_STORE; end
			8'b1000_011?: begin dec_timing = T_MOV_DIR_IND; dec_op = OP_MEM_STORE; end
			8'b1111_011?: begin
				dec_timing = T_MOV_IND_A;
				dec_op = OP_MEM_STORE;
				dec_src_acc = 1'b1;
			end
			8'b1010_011?, 8'b0111_011?: begin
				dec_timing = T_MOV_IND_SRC;
				dec_op = OP_MEM_STORE;
			end
			8'h90: begin dec_timing = T_MOV_POINTER; dec_op = OP_POINTER_LOAD; end
			8'h93, 8'h83: begin dec_timing = T_CODE_READ; dec_op = OP_CODE_READ; end
			8'b1110_001?, 8'hE0, 8'b1111_001?, 8'hF0: begin
				dec_timing = T_AUX_MOVE;
				dec_op = OP_AUX;
			end
			8'hC0: begin dec_timing = T_PUSH; dec_op = OP_MEM_STORE; end
			8'hD0: begin dec_timing = T_POP; dec_op = OP_MEM_STORE; end
			8'b1100_1???: begin dec_timing = T_EXCH_REG; dec_op = OP_EXCHANGE; end
			8'hC5: begin dec_timing = T_EXCH_DIR; dec_op = OP_EXCHANGE; end
			8'b1100_011?: begin dec_timing = T_EXCH_IND; dec_op = OP_EXCHANGE; end
			8'b1101_011?: begin dec_timing = T_EXCH_IND; dec_op = OP_NIBBLE_SWAP; end
			8'b0010_1???, 8'b0011_1???, 8'b1001_1???: begin
				dec_timing = T_ARITH_REG;
				dec_op = arith_op;
			end
			8'h25, 8'h35, 8'h95: begin dec_timing = T_ARITH_DIR; dec_op = arith_op; end
			8'b0010_011?, 8'b0011_011?, 8'b1001_011?: begin
				dec_timing = T_ARITH_IND;
				dec_op = arith_op;
			end
			8'h24, 8'h34, 8'h94: begin dec_timing = T_ARITH_IMM; dec_op = arith_op; end
			default: begin
				dec_timing = T_UNKNOWN;
				dec_op = OP_UNKNOWN;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// Execution timer
	// ----------------------------------------------------------------
	logic [2:0] count_reg;
	logic finish;

	assign finish = busy_reg && (count_reg == 3'h1);

	always_ff @(posedge clock) begin
		if (reset) begin
			busy_reg <= 1'b0;
			count_reg <= 3'h0;
		end else if (accept) begin
			busy_reg <= 1'b1;
			count_reg <= dec_timing.cyc;
		end else if (busy_reg) begin
			busy_reg <= !finish;
			count_reg <= count_reg - 3'h1;
		end
	end

	// ----------------------------------------------------------------
	// Captured operands
	// ----------------------------------------------------------------
	// Operands are taken with the opcode so the caller may move on at once
	cmae_op_e pend_op;
	logic pend_src_acc;
	logic pend_carry;
	logic [7:0] pend_acc;
	logic [7:0] pend_operand;
	logic [1:0] length_reg;
	logic [2:0] cycles_reg;
	logic [15:0] code_addr_reg;

	always_ff @(posedge clock) begin
		if (reset) begin
			pend_op <= OP_UNKNOWN;
			pend_src_acc <= 1'b0;
			pend_carry <= 1'b0;
			pend_acc <= BYTE_RESET;
			pend_operand <= BYTE_RESET;
			length_reg <= T_UNKNOWN.len;
			cycles_reg <= T_UNKNOWN.cyc;
			code_addr_reg <= ADDR_RESET;
		end else if (accept) begin
			pend_op <= dec_op;
			pend_src_acc <= dec_src_acc;
			pend_carry <= carry_in;
			pend_acc <= acc_in;
			pend_operand <= operand_in;
			length_reg <= dec_timing.len;
			cycles_reg <= dec_timing.cyc;
			if (dec_op == OP_CODE_READ) begin
				code_addr_reg <= 16'(acc_in) + ((opcode_in == OPC_CODE_READ_PC) ? pc_in : data_pointer_in);
			end
		end
	end

	// ----------------------------------------------------------------
	// Arithmetic
	// ----------------------------------------------------------------
	logic carry_term;
	logic [8:0] arith_full;
	logic [4:0] arith_low;
	logic arith_ov;

	always_comb begin
		carry_term = (pend_op != OP_ADD) && pend_carry;
		if (pend_op == OP_SUB_BORROW) begin
			arith_full = {1'b0, pend_acc} - {1'b0, pend_operand} - {8'h00, carry_term};
			arith_low = {1'b0, pend_acc[3:0]} - {1'b0, pend_operand[3:0]} - {4'h0, carry_term};
			arith_ov = (pend_acc[7] != pend_operand[7]) && (arith_full[7] != pend_acc[7]);
		end else begin
			arith_full = {1'b0, pend_acc} + {1'b0, pend_operand} + {8'h00, carry_term};
			arith_low = {1'b0, pend_acc[3:0]} + {1'b0, pend_operand[3:0]} + {4'h0, carry_term};
			arith_ov = (pend_acc[7] == pend_operand[7]) && (arith_full[7] != pend_acc[7]);
		end
	end

	// ----------------------------------------------------------------
	// Results
	// ----------------------------------------------------------------
	logic acc_write_next;
	logic mem_write_next;
	logic flags_write_next;
	logic [7:0] acc_result_next;
	logic [7:0] mem_result_next;

	always_comb begin
		acc_write_next = 1'b0;
		mem_write_next = 1'b0;
		flags_write_next = 1'b0;
		acc_result_next = pend_operand;
		mem_result_next = pend_src_acc ? pend_acc : pend_operand;
		unique case (pend_op)
			OP_ACC_LOAD, OP_CODE_READ: acc_write_next = 1'b1;
			OP_MEM_STORE: mem_write_next = 1'b1;
			OP_EXCHANGE: begin
				acc_write_next = 1'b1;
				mem_write_next = 1'b1;
				mem_result_next = pend_acc;
			end
			OP_NIBBLE_SWAP: begin
				acc_write_next = 1'b1;
				mem_write_next = 1'b1;
				acc_result_next = {pend_acc[7:4], pend_operand[3:0]};
				mem_result_next = {pend_operand[7:4], pend_acc[3:0]};
			end
			OP_ADD, OP_ADD_CARRY, OP_SUB_BORROW: begin
				acc_write_next = 1'b1;
				flags_write_next = 1'b1;
				acc_result_next = arith_full[7:0];
			end
			OP_POINTER_LOAD, OP_AUX, OP_UNKNOWN: acc_write_next = 1'b0;
		endcase
	end

	logic done_reg;
	logic unsupported_reg;
	logic unknown_reg;
	logic acc_write_reg;
	logic mem_write_reg;
	logic flags_write_reg;
	logic [7:0] acc_result_reg;
	logic [7:0] mem_result_reg;
	logic carry_reg;
	logic aux_carry_reg;
	logic overflow_reg;

	always_ff @(posedge clock) begin
		if (reset) begin
			done_reg <= 1'b0;
			acc_write_reg <= 1'b0;
			mem_write_reg <= 1'b0;
			flags_write_reg <= 1'b0;
		end else begin
			done_reg <= finish;
			acc_write_reg <= finish && acc_write_next;
			mem_write_reg <= finish && mem_write_next;
			flags_write_reg <= finish && flags_write_next;
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			unsupported_reg <= 1'b0;
			unknown_reg <= 1'b0;
			acc_result_reg <= BYTE_RESET;
			mem_result_reg <= BYTE_RESET;
			carry_reg <= 1'b0;
			aux_carry_reg <= 1'b0;
			overflow_reg <= 1'b0;
		end else if (finish) begin
			unsupported_reg <= (pend_op == OP_AUX);
			unknown_reg <= (pend_op == OP_UNKNOWN);
			acc_result_reg <= acc_result_next;
			mem_result_reg <= mem_result_next;
			if (flags_write_next) begin
				carry_reg <= arith_full[8];
				aux_carry_reg <= arith_low[4];
				overflow_reg <= arith_ov;
			end
		end
	end

	assign busy = busy_reg;
	assign done = done_reg;
	assign length = length_reg;
	assign cycles = cycles_reg;
	assign unsupported = unsupported_reg;
	assign unknown = unknown_reg;
	assign code_addr = code_addr_reg;
	assign acc_write = acc_write_reg;
	assign acc_result = acc_result_reg;
	assign mem_write = mem_write_reg;
	assign mem_result = mem_result_reg;
	assign flags_write = flags_write_reg;
	assign carry_out = carry_reg;
	assign aux_carry_out = aux_carry_reg;
	assign overflow_out = overflow_reg;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (reset);

	chk_aux_no_effect: assert property (accept && dec_op == OP_AUX |->
		##2 (done_reg && unsupported_reg && !mem_write_reg && !acc_write_reg && length_reg == 2'h1))
		else $error("aux move changed state or wrong timing");
	chk_reg_to_acc: assert property (accept && opcode_in[7:3] == 5'h1D |->
		##1 !done_reg ##1 (done_reg && acc_write_reg && length_reg == 2'h1))
		else $error("register to acc timing wrong");
	chk_acc_loads: assert property (accept && (opcode_in == 8'hE5 || opcode_in[7:1] == 7'h73) |->
		##1 busy_reg [*2] ##1 done_reg)
		else $error("acc load timing wrong");
	chk_imm_to_acc: assert property (accept && opcode_in == 8'h74 |->
		##3 (done_reg && acc_result_reg == $past(operand_in, 3) && length_reg == 2'h2))
		else $error("immediate acc load wrong");
	chk_acc_to_reg: assert property (accept && opcode_in[7:3] == 5'h1F |->
		##3 (mem_write_reg && mem_result_reg == $past(acc_in, 3)))
		else $error("acc to register wrong");
	chk_reg_loads: assert property (accept && opcode_in[7:3] == 5'h15 |->
		##1 busy_reg [*4] ##1 done_reg)
		else $error("register from direct timing wrong");
	chk_reg_imm: assert property (accept && opcode_in[7:3] == 5'h0F |-> ##3 done_reg)
		else $error("register immediate timing wrong");
	chk_direct_store: assert property (accept &&
		(opcode_in == 8'hF5 || opcode_in[7:3] == 5'h11) |-> ##4 (done_reg && mem_write_reg))
		else $error("direct store timing wrong");
	chk_direct_copy: assert property (accept && opcode_in == 8'h85 |->
		##5 (done_reg && length_reg == 2'h3))
		else $error("direct copy timing wrong");
	chk_direct_imm: assert property (accept && opcode_in == 8'h75 |-> ##4 done_reg)
		else $error("direct immediate timing wrong");
	chk_ind_to_direct: assert property (accept && opcode_in[7:1] == 7'h43 |-> ##5 done_reg)
		else $error("indirect to direct timing wrong");
	chk_ind_stores: assert property (accept && opcode_in[3:1] == 3'h3 &&
		(opcode_in[7:4] == 4'hF || opcode_in[7:4] == 4'hA || opcode_in[7:4] == 4'h7) |->
		##4 (done_reg && mem_write_reg))
		else $error("indirect store timing wrong");
	chk_data_pointer_16_load: assert property (accept && opcode_in == 8'h90 |->
		##4 (done_reg && length_reg == 2'h3 && !mem_write_reg))
		else $error("pointer load wrong");
	chk_code_address: assert property (accept && opcode_in == 8'h93 |->
		##1 (code_addr_reg == 16'($past(acc_in)) + $past(data_pointer_in)) ##4 done_reg)
		else $error("code read address or timing wrong");
	chk_stack_ops: assert property (accept && opcode_in == 8'hC0 |-> ##5 done_reg)
		else $error("push timing wrong");
	chk_pop_op: assert property (accept && opcode_in == 8'hD0 |-> ##4 done_reg)
		else $error("pop timing wrong");
	chk_exch_reg: assert property (accept && opcode_in[7:3] == 5'h19 |->
		##4 (acc_result_reg == $past(operand_in, 4) && mem_result_reg == $past(acc_in, 4)))
		else $error("register exchange wrong");
	chk_nibble_swap: assert property (accept && opcode_in[7:1] == 7'h6B |->
		##5 (done_reg && acc_result_reg[3:0] == $past(operand_in[3:0], 5)))
		else $error("nibble exchange wrong");
	chk_add_reg: assert property (accept && opcode_in[7:3] == 5'h05 |->
		##3 (flags_write_reg && acc_result_reg == 8'($past(acc_in, 3) + $past(operand_in, 3))))
		else $error("add result or timing wrong");
	chk_add_with_carry_carry: assert property (accept && opcode_in == 8'h34 |->
		##3 (acc_result_reg == 8'($past(acc_in, 3) + $past(operand_in, 3) + 8'($past(carry_in, 3)))))
		else $error("add with carry ignores carry");
	chk_sub_borrow_dir: assert property (accept && opcode_in == 8'h95 |->
		##4 (flags_write_reg && acc_result_reg ==
		8'($past(acc_in, 4) - $past(operand_in, 4) - 8'($past(carry_in, 4)))))
		else $error("subtract with borrow wrong");
	chk_busy_refuse: assert property (busy_reg && !finish |=> busy_reg)
		else $error("execution ended early");

	cov_arith: cover property (accept && dec_op == OP_SUB_BORROW ##3 flags_write_reg);
	cov_exchange: cover property (accept && dec_op == OP_NIBBLE_SWAP ##[1:5] mem_write_reg);
	cov_aux: cover property (accept && dec_op == OP_AUX ##2 unsupported_reg);
	cov_back_to_back: cover property (done_reg && accept);
endmodule : cmae_decoder
`default_nettype wire

// [verification/cmae_mem_model.sv]
// Behavioural scratch-pad RAM standing beside the decoder's operand and write ports
`timescale 1ns/10ps
`default_nettype none
module cmae_mem_model (
	input wire logic clock, // System clock
	input wire logic reset, // Synchronous, active high
	input wire logic [7:0] addr, // Byte selected by the bench
	input wire logic wr_en, // Write strobe from the core
	input wire logic [7:0] wr_data, // Byte to store
	output logic [7:0] rd_data, // Selected byte
	output logic [15:0] write_count // Writes seen since reset
);
	logic [7:0] ram_reg [0:255];
	// Scrambled contents, so a stale operand never matches by luck, and a zero one only at address 8'hA5
	initial begin
		for (int i = 0; i < 256; i++) begin
			ram_reg[i] = 8'(i) ^ 8'hA5;
		end
	end
	assign rd_data = ram_reg[addr];
	always @(posedge clock) begin
		if (wr_en) begin
			ram_reg[addr] <= wr_data;
		end
	end
	always @(posedge clock) begin
		if (reset) begin
			write_count <= 16'h0000;
		end else if (wr_en) begin
			write_count <= write_count + 16'h0001;
		end
	end
endmodule : cmae_mem_model
`default_nettype wire

// [verification/cpu_move_arith_exec_timing_tb.sv]
// Self-checking bench for the move, exchange and arithmetic decoder
`timescale 1ns/10ps
`default_nettype none
module cpu_move_arith_exec_timing_tb;
	import cmae_pkg::*;
	logic clock = 1'b0;
	logic reset = 1'b1;
	logic opcode_valid = 1'b0;
	logic [7:0] opcode_in = 8'h00;
	logic [7:0] acc_in = 8'h00;
	logic carry_in = 1'b0;
	logic [15:0] data_pointer_in = 16'h0000;
	logic [15:0] pc_in = 16'h0000;
	logic [7:0] mem_addr = 8'h00;
	logic [7:0] operand_in;
	logic [15:0] write_count;
	logic busy, done, unsupported, unknown, acc_write, mem_write, flags_write;
	logic carry_out, aux_carry_out, overflow_out;
	logic [1:0] length;
	logic [2:0] cycles;
	logic [15:0] code_addr;
	logic [7:0] acc_result, mem_result;
	int num_errors = 0;
	int checked = 0;
	// Nibbles: opcode, opcode, length, cycles
	logic [15:0] tbl [35] = '{16'hE811, 16'hE522, 16'hE612, 16'h7422, 16'hF812, 16'hA824,
		16'h7822, 16'hF523, 16'h8823, 16'h8534, 16'h8624, 16'h7533, 16'hF613, 16'hA623,
		16'h7623, 16'h9033, 16'h9314, 16'h8314, 16'hC024, 16'hD023, 16'hC813, 16'hC524,
		16'hC614, 16'hD614, 16'h2812, 16'h2523, 16'h2613, 16'h2422, 16'h3812, 16'h3523,
		16'h3613, 16'h3422, 16'h9812, 16'h9523, 16'h9613};
	logic [7:0] aux_ops [6] = '{8'hE0, 8'hE2, 8'hE3, 8'hF0, 8'hF2, 8'hF3};

	always #12.5 clock = ~clock;

	cmae_decoder u_dut (.clock(clock), .reset(reset), .opcode_valid(opcode_valid),
		.opcode_in(opcode_in), .operand_in(operand_in), .acc_in(acc_in),
		.carry_in(carry_in), .data_pointer_in(data_pointer_in), .pc_in(pc_in), .busy(busy),
		.done(done),
		.length(length), .cycles(cycles), .unsupported(unsupported), .unknown(unknown),
		.code_addr(code_addr), .acc_write(acc_write), .acc_result(acc_result),
		.mem_write(mem_write), .mem_result(mem_result), .flags_write(flags_write),
		.carry_out(carry_out), .aux_carry_out(aux_carry_out), .overflow_out(overflow_out));

	cmae_mem_model u_mem (.clock(clock), .reset(reset), .addr(mem_addr), .wr_en(mem_write),
		.wr_data(mem_result), .rd_data(operand_in), .write_count(write_count));

	// ----------------------------------------------------------------
	// Compare and drive helpers
	// ----------------------------------------------------------------
	task automatic chk_val(input string what, input logic [15:0] exp, input logic [15:0] got);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk_val

	task automatic chk_bit(input string what, input logic exp, input logic got);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %s expected %b seen %b", what, exp, got);
		end
	endtask : chk_bit

	// Entered at a falling edge; returns at the falling edge where done stands
	task automatic issue(input logic [7:0] op, input logic [7:0] a, input logic [1:0] len,
		input logic [2:0] cyc);
		int n;
		n = 0;
		opcode_valid = 1'b1;
		opcode_in = op;
		acc_in = a;
		@(negedge clock);
		opcode_valid = 1'b0;
		chk_val("length", 16'(len), 16'(length));
		chk_val("cycles", 16'(cyc), 16'(cycles));
		while (done !== 1'b1 && n < 8) begin
			if (busy === 1'b1) begin
				n++;
			end
			@(negedge clock);
		end
		chk_val("busy cycles", 16'(cyc), 16'(n));
		chk_bit("done", 1'b1, done);
	endtask : issue

	task automatic arith(input logic [7:0] op, input logic [7:0] a, input logic [7:0] b,
		input logic c, input logic [1:0] len, input logic [2:0] cyc, input logic [7:0] res,
		input logic [2:0] f);
		mem_addr = b ^ 8'hA5;
		carry_in = c;
		issue(op, a, len, cyc);
		chk_val("acc_result", 16'(res), 16'(acc_result));
		chk_bit("flags_write", 1'b1, flags_write);
		chk_bit("acc_write", 1'b1, acc_write);
		chk_val("flags", 16'(f), 16'({carry_out, aux_carry_out, overflow_out}));
	endtask : arith

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_timing();
		mem_addr = 8'h80;
		for (int i = 0; i < 35; i++) begin
			issue(tbl[i][15:8], 8'h42, tbl[i][5:4], tbl[i][2:0]);
		end
	endtask : t_timing

	task automatic t_arith();
		arith(8'h25, 8'h7F, 8'h01, 1'b1, 2'h2, 3'h3, 8'h80, 3'b011);
		arith(8'h36, 8'hFF, 8'h00, 1'b1, 2'h1, 3'h3, 8'h00, 3'b110);
		arith(8'h34, 8'h10, 8'h20, 1'b1, 2'h2, 3'h2, 8'h31, 3'b000);
		arith(8'h98, 8'h00, 8'h01, 1'b0, 2'h1, 3'h2, 8'hFF, 3'b110);
		arith(8'h95, 8'h80, 8'h01, 1'b0, 2'h2, 3'h3, 8'h7F, 3'b011);
	endtask : t_arith

	task automatic t_code();
		mem_addr = 8'h20;
		data_pointer_in = 16'h1234;
		pc_in = 16'h00FF;
		issue(8'h93, 8'h10, 2'h1, 3'h4);
		chk_val("code_addr", 16'h1244, code_addr);
		chk_val("acc_result", 16'h0085, 16'(acc_result));
		issue(8'h83, 8'hF0, 2'h1, 3'h4);
		chk_val("code_addr", 16'h01EF, code_addr);
	endtask : t_code

	task automatic t_xch();
		mem_addr = 8'h10;
		issue(8'hC5, 8'h3C, 2'h2, 3'h4);
		chk_val("acc_result", 16'h00B5, 16'(acc_result));
		chk_bit("mem_write", 1'b1, mem_write);
		@(negedge clock);
		chk_val("stored byte", 16'h003C, 16'(operand_in));
		mem_addr = 8'h11;
		issue(8'hD6, 8'h3C, 2'h1, 3'h4);
		chk_val("acc_result", 16'h0034, 16'(acc_result));
		@(negedge clock);
		chk_val("stored byte", 16'h00BC, 16'(operand_in));
	endtask : t_xch

	task automatic t_aux();
		logic [15:0] wc;
		for (int i = 0; i < 6; i++) begin
			wc = write_count;
			issue(aux_ops[i], 8'h55, 2'h1, 3'h1);
			chk_bit("unsupported", 1'b1, unsupported);
			chk_bit("acc_write", 1'b0, acc_write);
			chk_bit("mem_write", 1'b0, mem_write);
			@(negedge clock);
			chk_val("write count", wc, write_count);
		end
		issue(8'hE8, 8'h55, 2'h1, 3'h1);
		chk_bit("unsupported", 1'b0, unsupported);
		issue(8'h00, 8'h55, 2'h1, 3'h1);
		chk_bit("unknown", 1'b1, unknown);
	endtask : t_aux

	// A second opcode offered while busy must leave the first one intact
	task automatic t_refuse();
		int n;
		n = 0;
		mem_addr = 8'h05 ^ 8'hA5;
		carry_in = 1'b0;
		opcode_valid = 1'b1;
		opcode_in = 8'h25;
		acc_in = 8'h10;
		@(negedge clock);
		opcode_in = 8'hE8;
		@(negedge clock);
		chk_bit("busy", 1'b1, busy);
		opcode_valid = 1'b0;
		while (done !== 1'b1 && n < 8) begin
			n++;
			@(negedge clock);
		end
		chk_val("acc_result", 16'h0015, 16'(acc_result));
		chk_val("length", 16'h0002, 16'(length));
	endtask : t_refuse

	task automatic end_of_test();
		$display("Comparisons %0d mismatches %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : end_of_test

	initial begin
		#(25 * 5000);
		num_errors++;
		end_of_test();
	end

	initial begin
		repeat (16) @(posedge clock);
		@(negedge clock);
		reset = 1'b0;
		@(negedge clock);
		t_arith();
		t_code();
		t_xch();
		t_aux();
		t_refuse();
		t_timing();
		end_of_test();
	end
endmodule : cpu_move_arith_exec_timing_tb
`default_nettype wire
